// [rtl/cbsr_regs.sv]
// SMBus slave and control/status register bank of a differential clock buffer.
// Assumes SCL and SDA come from open-drain pins resolved outside, and that the
// three-level mode strap is already digitised to 00, 01 or 11 by a comparator.
`timescale 1ns/1ps

// Summary of operation
// - Mode byte bits 7:6 read back the strap-latched PLL mode.
// - Mode byte bit 3 picks strap (0) or register (1) mode; resets 0.
// - With override on, mode byte bits 2:1 select PLL mode; reset 11.
// - Readback bits keep the strap value after a software override.
// - Mode byte bit 0 reads frequency strap: 0 is 133MHz, 1 is 100MHz.
// - Output enables reset 1; 0 forces low, 1 passes active-low pin control.
// - Byte 1 bits 1,2,4..7 map outputs 0..5; byte 2 bits 0,2 outputs 6,7.
// - Bytes 3, 4, 8 and reserved bits read zero, writes ignored.
// - Byte 5 reads fixed revision (high nibble) and vendor (low nibble).
// - Byte 6 reads a fixed eight-bit device identifier.
// - Byte 7 bits 4:0 set block read length; default 8.
// - Block write: address, index, count, data; device acks each byte.
// - Block read: index, repeated start, read address, count then data.
module cbsr_regs
   import cbsr_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h20,
   parameter logic [3:0] REV_ID     = 4'h3,  // Arbitrary value.
   parameter logic [3:0] VENDOR_ID  = 4'hA,  // Arbitrary value.
   parameter logic [7:0] DEVICE_ID  = 8'h5A  // Arbitrary value.
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic [1:0] pllModeStrapPin,
   input  wire logic       frequencySelectStrap,
   input  wire logic [7:0] outputEnablePin_n,
   output logic [1:0]      pllModeOut,
   output logic [7:0]      outputRun
);

   cbsr_q_t q;
   cbsr_q_t d;
   logic    sclRise;
   logic    sclFall;
   logic    startDet;
   logic    stopDet;

   // Reads one byte of the bank; unmapped and reserved bytes give zero.
   function automatic logic [7:0] regRead(input logic [7:0] idx, input cbsr_q_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         IDX_MODE_FREQ:  v = {s.strapMode, 2'h0, s.swEn, s.swMode, s.freqSel};
         IDX_OE_LOW:     v = {s.outEn[5:2], 1'b0, s.outEn[1:0], 1'b0};
         IDX_OE_HIGH:    v = {5'h00, s.outEn[7], 1'b0, s.outEn[6]};
         IDX_REV_VENDOR: v = {REV_ID, VENDOR_ID};
         IDX_DEVICE:     v = DEVICE_ID;
         IDX_READ_COUNT: v = {3'h0, s.readCount};
         default:        v = 8'h00;
      endcase
      return v;
   endfunction

   // Edge and condition detection looks only at the second and third stages.
   assign sclRise  = q.sclS2 & ~q.sclS3;
   assign sclFall  = ~q.sclS2 & q.sclS3;
   assign startDet = q.sclS2 & q.sclS3 & q.sdaS3 & ~q.sdaS2;
   assign stopDet  = q.sclS2 & q.sclS3 & ~q.sdaS3 & q.sdaS2;

   // Next-state logic for the whole block.
   always_comb begin
      d         = q;
      d.sclS1   = sclIn;
      d.sclS2   = q.sclS1;
      d.sclS3   = q.sclS2;
      d.sdaS1   = sdaIn;
      d.sdaS2   = q.sdaS1;
      d.sdaS3   = q.sdaS2;
      d.pinS1   = outputEnablePin_n;
      d.pinS2   = q.pinS1;
      d.strapS1 = {frequencySelectStrap, pllModeStrapPin};
      d.strapS2 = q.strapS1;

      // The straps are caught once the synchroniser has filled, then frozen.
      if (!q.strapDone) begin
         if (q.strapWait == STRAP_SETTLE) begin
            d.strapDone = 1'b1;
            d.strapMode = q.strapS2[1:0];
            d.freqSel   = q.strapS2[2];
         end else begin
            d.strapWait = q.strapWait + 2'h1;
         end
      end

      // Effective mode and gated outputs.
      d.modeOut = q.swEn ? q.swMode : q.strapMode;
      d.runOut  = q.outEn & ~q.pinS2;

      // Start and stop override whatever the byte engine is doing.
      if (startDet) begin
         d.state  = ST_RECV;
         d.kind   = KIND_ADDR;
         d.bitCnt = 3'h0;
         d.sdaOe  = 1'b0;
         d.byteReady = 1'b0;
      end else if (stopDet) begin
         d.state = ST_IDLE;
         d.sdaOe = 1'b0;
      end else begin
         unique case (q.state)
            ST_IDLE: begin
               d.sdaOe = 1'b0;
            end
            // Bits are taken on the clock rise; the ack goes out on the fall that ends the eighth bit.
            ST_RECV: begin
               if (sclRise) begin
                  d.shift  = {q.shift[6:0], q.sdaS2};
                  d.bitCnt = q.bitCnt + 3'h1;
                  d.byteReady = (q.bitCnt == BIT_LAST);
               end else if (sclFall && q.byteReady) begin
                  d.byteReady = 1'b0;
                  d.state = ST_ACKD;
                  d.sdaOe = 1'b1;
                  unique case (q.kind)
                     KIND_ADDR: begin
                        if (q.shift[7:1] != SLAVE_ADDR) begin
                           d.state = ST_IDLE;
                           d.sdaOe = 1'b0;
                        end
                        d.isRead = q.shift[0];
                        d.kind   = KIND_INDEX;
                     end
                     KIND_INDEX: begin
                        d.index = q.shift;
                        d.kind  = KIND_COUNT;
                     end
                     KIND_COUNT: begin
                        d.remaining = q.shift;
                        d.kind      = KIND_DATA;
                     end
                     KIND_DATA: begin
                        // Bytes past the announced count are acked and dropped.
                        if (q.remaining != 8'h00) begin
                           d.remaining = q.remaining - 8'h01;
                           d.index     = q.index + 8'h01;
                           unique case (q.index)
                              IDX_MODE_FREQ: begin
                                 d.swEn   = q.shift[MODE_SW_EN_BIT];
                                 d.swMode = {q.shift[MODE_SW_HI_BIT], q.shift[MODE_SW_LO_BIT]};
                              end
                              IDX_OE_LOW: begin
                                 d.outEn[1:0] = q.shift[2:1];
                                 d.outEn[5:2] = q.shift[7:4];
                              end
                              IDX_OE_HIGH: begin
                                 d.outEn[6] = q.shift[0];
                                 d.outEn[7] = q.shift[2];
                              end
                              IDX_READ_COUNT: begin
                                 d.readCount = q.shift[4:0];
                              end
                              default: begin
                                 // Read-only and reserved bytes keep their contents.
                                 d.readCount = q.readCount;
                              end
                           endcase
                        end
                     end
                  endcase
               end
            end
            ST_ACKD: begin
               // Release the ack; a read address starts the count byte here.
               if (sclFall) begin
                  d.bitCnt = 3'h0;
                  if (q.isRead && q.kind == KIND_INDEX) begin
                     d.state = ST_SEND;
                     // The count byte's top bit is always zero, so the line goes low at once.
                     d.sdaOe = 1'b1;
                     d.shift = {2'h0, q.readCount, 1'b0};
                  end else begin
                     d.state = ST_RECV;
                     d.sdaOe = 1'b0;
                  end
               end
            end
            // Each clock fall puts out the next bit, so it has settled well before the host's rise.
            ST_SEND: begin
               if (sclFall) begin
                  d.sdaOe = ~q.shift[7];
                  d.shift = {q.shift[6:0], 1'b0};
               end else if (sclRise) begin
                  d.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == BIT_LAST) begin
                     d.state = ST_HACK;
                  end
               end
            end
            ST_HACK: begin
               // Host ack fetches the next byte; a nack ends the read.
               if (sclFall) begin
                  d.sdaOe = 1'b0;
               end else if (sclRise) begin
                  if (!q.sdaS2) begin
                     d.shift  = regRead(q.index, q);
                     d.index  = q.index + 8'h01;
                     d.bitCnt = 3'h0;
                     d.state  = ST_SEND;
                  end else begin
                     d.state = ST_IDLE;
                  end
               end
            end
            default: begin
               d.state = ST_IDLE;
               d.sdaOe = 1'b0;
            end
         endcase
      end
   end

   // Register stage; reset gives the power-up defaults.
   // The SCL and SDA synchronisers reset to the idle-high bus level, so no false edge or start follows reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q           <= '0;
         q.state     <= ST_IDLE;
         q.sclS1     <= 1'b1;
         q.sclS2     <= 1'b1;
         q.sclS3     <= 1'b1;
         q.sdaS1     <= 1'b1;
         q.sdaS2     <= 1'b1;
         q.sdaS3     <= 1'b1;
         q.pinS1     <= 8'hFF;
         q.pinS2     <= 8'hFF;
         q.swMode    <= SW_MODE_RST;
         q.outEn     <= OUT_EN_RST;
         q.readCount <= READ_CNT_RST;
      end else begin
         q <= d;
      end
   end

   assign sdaOut     = q.sdaLvl;
   assign sdaOe      = q.sdaOe;
   assign pllModeOut = q.modeOut;
   assign outputRun  = q.runOut;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   mode_select_a: assert property (q.swEn |=> pllModeOut == $past(q.swMode))
      else $error("Software mode not applied to PLL mode output.");

   strap_hold_a: assert property (q.strapDone |=> $stable(q.strapMode) && $stable(q.freqSel))
      else $error("Latched strap value changed after capture.");

   reserved_zero_a: assert property (regRead(IDX_RSVD_THREE, q) == 8'h00 && regRead(IDX_RSVD_EIGHT, q) == 8'h00
                                     && regRead(IDX_RSVD_FOUR, q) == 8'h00)
      else $error("Reserved byte read nonzero.");

   // Every cleared enable bit holds its output low one cycle later, whatever its pin says.
   output_force_a: assert property ((outputRun & ~$past(q.outEn)) == 8'h00)
      else $error("Disabled output still running.");

   reset_default_a: assert property ($fell(sys_rst) |-> q.readCount == READ_CNT_RST && !q.swEn
                                     && q.swMode == SW_MODE_RST && q.outEn == OUT_EN_RST)
      else $error("Register defaults wrong after reset.");

   ack_drive_a: assert property ($changed(q.state) && q.state == ST_ACKD |-> sdaOe)
      else $error("Byte accepted without driving ack.");

   read_count_a: assert property (q.state == ST_ACKD && q.isRead && q.kind == KIND_INDEX && sclFall
                                  && !startDet && !stopDet |=> q.state == ST_SEND && sdaOe)
      else $error("Read address not followed by count byte.");

   stop_idle_a: assert property (stopDet && !startDet |=> q.state == ST_IDLE && !sdaOe)
      else $error("Stop did not return slave to idle.");

   // Read data may move only while the clock is low; a move with it high would look like a start or stop.
   send_stable_a: assert property (q.state == ST_SEND && q.sclS2 && q.sclS3 && !startDet
                                   && !stopDet |=> $stable(sdaOe))
      else $error("Read data moved while the clock was high.");

   // A host nack on the ninth bit ends the read and leaves the line released.
   nack_idle_a: assert property (q.state == ST_HACK && sclRise && q.sdaS2 && !startDet
                                 && !stopDet |=> q.state == ST_IDLE && !sdaOe)
      else $error("Host nack did not end the read.");

   // A host ack fetches the next byte and steps the index by one.
   read_next_a: assert property (q.state == ST_HACK && sclRise && !q.sdaS2 && !startDet
                                 && !stopDet |=> q.state == ST_SEND && q.index == $past(q.index) + 8'h01)
      else $error("Host ack did not fetch the next byte.");

   // A counted data byte is acknowledged and taken off the announced count.
   write_step_a: assert property (q.state == ST_RECV && sclFall && q.byteReady && q.kind == KIND_DATA
                                  && q.remaining != 8'h00 && !startDet && !stopDet
                                  |=> q.remaining == $past(q.remaining) - 8'h01 && sdaOe)
      else $error("Written byte not counted and acknowledged.");

endmodule

// [rtl/cbsr_pkg.sv]
// Constants and state types of the clock buffer SMBus register bank.
// Assumes one 50 MHz clock and a synchronous power-up reset.
package cbsr_pkg;

   // Byte indices of the register bank.
   localparam logic [7:0] IDX_MODE_FREQ  = 8'h00;
   localparam logic [7:0] IDX_OE_LOW     = 8'h01;
   localparam logic [7:0] IDX_OE_HIGH    = 8'h02;
   localparam logic [7:0] IDX_RSVD_THREE = 8'h03;
   localparam logic [7:0] IDX_RSVD_FOUR  = 8'h04;
   localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
   localparam logic [7:0] IDX_DEVICE     = 8'h06;
   localparam logic [7:0] IDX_READ_COUNT = 8'h07;
   localparam logic [7:0] IDX_RSVD_EIGHT = 8'h08;

   // Field positions inside the mode byte.
   localparam int MODE_SW_EN_BIT = 3;
   localparam int MODE_SW_HI_BIT = 2;
   localparam int MODE_SW_LO_BIT = 1;

   // Mode codes: low bandwidth, bypass, high bandwidth.
   localparam logic [1:0] MODE_LOW_BW  = 2'h0;
   localparam logic [1:0] MODE_BYPASS  = 2'h1;
   localparam logic [1:0] MODE_HIGH_BW = 2'h3;

   // Reset values and counter limits.
   localparam logic [1:0] SW_MODE_RST  = 2'h3;
   localparam logic [7:0] OUT_EN_RST   = 8'hFF;
   localparam logic [4:0] READ_CNT_RST = 5'h08;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [2:0] BIT_LAST     = 3'h7;

   // Kind of byte being received.
   localparam logic [1:0] KIND_ADDR  = 2'h0;
   localparam logic [1:0] KIND_INDEX = 2'h1;
   localparam logic [1:0] KIND_COUNT = 2'h2;
   localparam logic [1:0] KIND_DATA  = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACKD = 5'h04,
      ST_SEND = 5'h08,
      ST_HACK = 5'h10
   } cbsr_state_t;

   typedef struct packed {
      cbsr_state_t state;
      logic        sclS1;
      logic        sclS2;
      logic        sclS3;
      logic        sdaS1;
      logic        sdaS2;
      logic        sdaS3;
      logic [7:0]  pinS1;
      logic [7:0]  pinS2;
      logic [2:0]  strapS1;
      logic [2:0]  strapS2;
      logic [1:0]  strapWait;
      logic        strapDone;
      logic [1:0]  strapMode;
      logic        freqSel;
      logic        swEn;
      logic [1:0]  swMode;
      logic [7:0]  outEn;
      logic [4:0]  readCount;
      logic [1:0]  kind;
      logic [2:0]  bitCnt;
      logic        byteReady;
      logic        isRead;
      logic [7:0]  shift;
      logic [7:0]  index;
      logic [7:0]  remaining;
      logic        sdaOe;
      logic        sdaLvl;
      logic [1:0]  modeOut;
      logic [7:0]  runOut;
   } cbsr_q_t;

endpackage

// [verif/cbsr_host.sv]
// SMBus host model that drives the clock line and pulls the data line low.
// Assumes the data wire is resolved with a pull-up outside and fed back on sda.
`timescale 1ns/1ps
module cbsr_host (
   input  wire logic       clk,
   input  wire logic       sda,
   output logic            scl,
   output logic            sdaLow,
   output logic            gotByte,
   output logic [7:0]      gotData,
   output logic            ackAll
);
   // Both lines start released, so the bus idles high.
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
      gotByte = 1'b0;
      gotData = 8'h00;
      ackAll = 1'b0;
   end

   // Lines change just after a falling edge and stand for n cycles.
   task automatic phase(input logic c, input logic l, input int n);
      scl = c;
      sdaLow = l;
      repeat (n) @(negedge clk);
   endtask

   // Start and repeated start; phases are long so the synchronisers settle.
   task automatic sendStart();
      phase(1'b0, 1'b0, 10);
      phase(1'b1, 1'b0, 10);
      phase(1'b1, 1'b1, 10);
      phase(1'b0, 1'b1, 4);
   endtask

   task automatic sendStop();
      phase(1'b0, 1'b1, 10);
      phase(1'b1, 1'b1, 10);
      phase(1'b1, 1'b0, 10);
   endtask

   // Data is held 4 cycles past the clock fall so it never races the edge.
   task automatic bitIo(input logic b, output logic r);
      phase(1'b0, !b, 8);
      phase(1'b1, !b, 5);
      r = sda;
      phase(1'b1, !b, 5);
      phase(1'b0, !b, 4);
   endtask

   task automatic wrByte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(d[i], r);
      bitIo(1'b1, r);
      ackAll &= !r;
   endtask

   // The host acknowledges every byte but the last one.
   task automatic rdByte(input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, r);
         gotData[i] = r;
      end
      bitIo(last, r);
      gotByte = 1'b1;
      repeat (1) @(negedge clk);
      gotByte = 1'b0;
   endtask

   // A block write when nRd is 0, otherwise a block read of nRd data bytes.
   task automatic xfer(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] wr[$], input int nRd);
      ackAll = 1'b1;
      sendStart();
      wrByte({adr, 1'b0});
      wrByte(idx);
      if (nRd == 0) begin
         wrByte(8'(wr.size()));
         foreach (wr[i]) wrByte(wr[i]);
      end else begin
         sendStart();
         wrByte({adr, 1'b1});
         for (int i = 0; i <= nRd; i++) rdByte(i == nRd);
      end
      sendStop();
   endtask
endmodule

// [verif/clock_buffer_smbus_regs_bench.sv]
// Self-checking bench of the register bank, driving it through the host model.
// Assumes an open-drain data wire with a pull-up and digitised strap codes.
`timescale 1ns/1ps
module clock_buffer_smbus_regs_bench;
   import cbsr_pkg::*;
   localparam logic [6:0] ADR = 7'h20;
   localparam logic [3:0] REV = 4'h6;  // Arbitrary value.
   localparam logic [3:0] VEN = 4'h9;  // Arbitrary value.
   localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic        scl, sdaLow, sdaWire, sdaOut, sdaOe, freqStrap, gotByte, ackAll;
   logic [1:0]  strap, pllModeOut;
   logic [7:0]  pinN, outputRun, gotData;
   logic [7:0]  expQ[$];
   logic [31:0] seed;
   logic [1:0]  codes[3] = '{MODE_HIGH_BW, MODE_LOW_BW, MODE_BYPASS};
   int          n_errors = 0;
   int          num_checks = 0;

   always #10 clk = ~clk;
   // Wired-AND of both pull-downs; released means the pull-up level.
   assign sdaWire = !(sdaLow || sdaOe);

   cbsr_regs #(.SLAVE_ADDR(ADR), .REV_ID(REV), .VENDOR_ID(VEN), .DEVICE_ID(DEV)) dut (
      .clk(clk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .pllModeStrapPin(strap), .frequencySelectStrap(freqStrap), .outputEnablePin_n(pinN),
      .pllModeOut(pllModeOut), .outputRun(outputRun));

   cbsr_host host (.clk(clk), .sda(sdaWire), .scl(scl), .sdaLow(sdaLow), .gotByte(gotByte),
      .gotData(gotData), .ackAll(ackAll));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // New random pin levels, then a settled look at the gated outputs.
   task automatic pinCheck(input logic [7:0] en);
      seed = lfsr(seed);
      pinN = seed[7:0];
      repeat (10) @(negedge clk);
      check(outputRun, en & ~pinN);
   endtask

   // Every byte the host receives is matched against the oldest note.
   always @(posedge clk) begin
      if (gotByte === 1'b1) check(gotData, (expQ.size() > 0) ? expQ.pop_front() : 8'hXX);
   end

   // A hang is cut short here and counted as a mismatch.
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      results();
   end

   // Main sequence; straps move after capture to prove they stay frozen.
   initial begin
      strap = MODE_BYPASS;
      freqStrap = 1'b1;
      pinN = 8'h00;
      seed = 32'h3D40B26F;
      repeat (5) @(negedge clk);
      sysRst = 1'b0;
      repeat (20) @(negedge clk);
      strap = MODE_HIGH_BW;
      freqStrap = 1'b0;
      pinCheck(8'hFF);
      check({6'h00, pllModeOut}, {6'h00, MODE_BYPASS});
      expQ = '{8'h08, 8'h47, 8'hF6, 8'h05, 8'h00, 8'h00, {REV, VEN}, DEV, 8'h08, 8'h00};
      host.xfer(ADR, IDX_MODE_FREQ, '{}, 9);
      foreach (codes[i]) begin
         host.xfer(ADR, IDX_MODE_FREQ, '{{5'h19, codes[i], 1'b0}}, 0);
         check({6'h00, pllModeOut}, {6'h00, codes[i]});
      end
      host.xfer(ADR, IDX_OE_LOW, '{8'h2D, 8'hFB, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hE3}, 0);
      check({7'h00, ackAll}, 8'h01);
      pinCheck(8'h4A);
      expQ = '{8'h03, 8'h4B, 8'h24, 8'h01, 8'h00, 8'h00, {REV, VEN}, DEV, 8'h03};
      host.xfer(ADR, IDX_MODE_FREQ, '{}, 8);
      host.xfer(ADR ^ 7'h01, IDX_OE_LOW, '{8'h00}, 0);
      check({7'h00, ackAll}, 8'h00);
      pinCheck(8'h4A);
      // Warm reset after the mode change; straps are captured afresh.
      sysRst = 1'b1;
      repeat (5) @(negedge clk);
      sysRst = 1'b0;
      repeat (20) @(negedge clk);
      check({6'h00, pllModeOut}, {6'h00, MODE_HIGH_BW});
      expQ = '{8'h08, 8'h08};
      host.xfer(ADR, IDX_READ_COUNT, '{}, 1);
      check(8'(expQ.size()), 8'h00);
      check({7'h00, sdaOut}, 8'h00);
      results();
   end
endmodule
